// ---- design/pcs_core.v ----
`timescale 1ns/1ps
`include "pcs_consts.vh"
// Summary of operation
// - 13-bit program counter; low byte readable and writable.
// - Upper bits unreadable; set from the high latch, the vector address, the stack or increment carry.
// - Any reset clears the upper program-counter bits.
// - Low-byte write loads upper bits from latch bits 3:0, top bit zero.
// - Jumps take 11 bits from instruction; top two are zero and latch bit 3.
// - Computed jump loads low byte, upper bits from latch; no page carry.
// - Eight-entry 13-bit stack, pointer not accessible.
// - Push on subroutine jump and interrupt vectoring.
// - Pop on return, return with literal, interrupt exit.
// - Push and pop leave the high latch untouched.
// - Stack is circular; ninth push overwrites first.
// - No overflow or underflow status.
// - Full 13-bit PC stored on push.
// - 8K-word program space in 2K pages.
// - Latch bit 4 ignored by this variant.
module pcs_core (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Core decode
  input wire i_step,
  input wire i_jump,
  input wire i_call,
  input wire [10:0] i_jump_addr,
  input wire i_return,
  input wire i_exit_with_literal_instr,
  input wire i_interrupt_exit_instr,
  input wire i_int_vector,
  input wire [12:0] i_vector_addr,
  input wire i_low_wr,
  input wire [7:0] i_low_wdata,
  input wire i_latch_wr,
  input wire [7:0] i_latch_wdata,
  // Program address out
  output reg [12:0] o_pc,
  output wire [7:0] o_pc_low_byte,
  output wire [7:0] o_pc_high_latch,
  // AXI4-Lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // ----------------------------------------
  // Update selection
  // ----------------------------------------
  localparam [5:0] UPD_HOLD = 6'h01;
  localparam [5:0] UPD_VEC = 6'h02;
  localparam [5:0] UPD_POP = 6'h04;
  localparam [5:0] UPD_JMP = 6'h08;
  localparam [5:0] UPD_LOW = 6'h10;
  localparam [5:0] UPD_INC = 6'h20;

  // 13 bits span 8K words in 2K pages
  reg [12:0] pc_q;
  reg [12:0] pc_d;
  reg [7:0] latch_q;
  reg [7:0] latch_d;
  reg [5:0] upd;
  reg pop_pend_q;
  wire any_ret;
  wire push;
  wire pop;
  wire [2:0] ptr;
  wire [2:0] top;
  wire [12:0] stk_rdata;
  wire [12:0] pc_inc;
  wire [4:0] low_upper;
  wire [1:0] jmp_page;

  // AXI side signals
  reg aw_have_q;
  reg w_have_q;
  reg [3:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg ax_low_wr;
  reg ax_latch_wr;
  wire wr_fire;

  assign any_ret = i_return | i_exit_with_literal_instr | i_interrupt_exit_instr;
  assign push = i_int_vector | i_call;
  assign pop = any_ret & ~push;
  assign pc_inc = pc_q + 13'h0001;
  // bit 4 ignored, only 4K reachable through bits 4:3 minus bit 4
  assign jmp_page = {1'b0, latch_q[`PCS_LATCH_PG_LO]};
  assign low_upper = {1'b0, latch_q[3:0]};

  // ----------------------------------------
  // Return stack
  // ----------------------------------------
  // pointer kept internal
  pcs_stack_ptr u_ptr (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_push(push),
    .i_pop(pop),
    .o_ptr_q(ptr),
    .o_top(top)
  );

  pcs_stack_mem u_mem (
    .i_clk(i_clk),
    .i_we(push),
    .i_waddr(ptr),
    .i_wdata(i_call ? pc_inc : pc_q),
    .i_raddr(top),
    .o_rdata(stk_rdata)
  );

  // ----------------------------------------
  // Program counter next value
  // ----------------------------------------
  // one update, fixed priority
  always @* begin
    if (i_int_vector) begin
      upd = UPD_VEC;
    end else if (pop_pend_q) begin
      upd = UPD_POP;
    end else if (i_jump | i_call) begin
      upd = UPD_JMP;
    end else if (i_low_wr | ax_low_wr) begin
      upd = UPD_LOW;
    end else if (i_step & ~pop) begin
      upd = UPD_INC;
    end else begin
      upd = UPD_HOLD;
    end
  end

  always @* begin
    pc_d = pc_q;
    case (upd)
      UPD_VEC: begin
        pc_d = i_vector_addr;
      end
      UPD_POP: begin
        pc_d = stk_rdata;
      end
      UPD_JMP: begin
        // page from latch, offset from instruction
        pc_d = {jmp_page, i_jump_addr};
      end
      UPD_LOW: begin
        pc_d = {low_upper, (i_low_wr ? i_low_wdata : w_data_q[7:0])};
      end
      UPD_INC: begin
        pc_d = pc_inc;
      end
      default: begin
        pc_d = pc_q;
      end
    endcase
  end

  // latch written only by software, never by stack
  always @* begin
    latch_d = latch_q;
    if (i_latch_wr) begin
      latch_d = i_latch_wdata;
    end else if (ax_latch_wr) begin
      latch_d = w_data_q[7:0];
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      pc_q <= {`PCS_UPPER_RESET, `PCS_LOW_RESET};
      latch_q <= `PCS_LATCH_RESET;
      pop_pend_q <= 1'b0;
      o_pc <= 13'h0000;
    end else begin
      pc_q <= pc_d;
      latch_q <= latch_d;
      // Stack read is registered, so PC loads popped value on the second edge after the pop
      pop_pend_q <= pop;
      o_pc <= pc_d;
    end
  end

  // low byte visible; upper bits not exposed
  assign o_pc_low_byte = pc_q[7:0];
  assign o_pc_high_latch = latch_q;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Decode the pending write; applied to PC below jumps, above increment
  always @* begin
    ax_low_wr = 1'b0;
    ax_latch_wr = 1'b0;
    if (wr_fire & w_strb_q[0]) begin
      if (aw_addr_q == `PCS_ADDR_LOW) begin
        ax_low_wr = 1'b1;
      end else if (aw_addr_q == `PCS_ADDR_LATCH) begin
        ax_latch_wr = 1'b1;
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q == `PCS_ADDR_LOW || aw_addr_q == `PCS_ADDR_LATCH) begin
          s_axi_bresp <= `PCS_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PCS_RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PCS_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PCS_RESP_OKAY;
      case (s_axi_araddr)
        `PCS_ADDR_LOW: begin
          s_axi_rdata <= {24'h000000, pc_q[7:0]};
        end
        `PCS_ADDR_LATCH: begin
          s_axi_rdata <= {24'h000000, latch_q};
        end
        // upper PC bits never readable, so no page status
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PCS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pcs_core

// ---- design/pcs_consts.vh ----
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH
// ----------------------------------------
// Widths
// ----------------------------------------
`define PCS_PC_W 13
`define PCS_DEPTH 8
`define PCS_PTR_W 3
`define PCS_JMP_W 11
// ----------------------------------------
// Register byte addresses (AXI4-Lite)
// ----------------------------------------
`define PCS_ADDR_LOW 4'h0
`define PCS_ADDR_LATCH 4'h4
`define PCS_ADDR_STAT 4'h8
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define PCS_LATCH_PG_HI 4
`define PCS_LATCH_PG_LO 3
`define PCS_LOW_RESET 8'h00
`define PCS_LATCH_RESET 8'h00
`define PCS_UPPER_RESET 5'h00
`define PCS_RESP_OKAY 2'h0
`define PCS_RESP_SLVERR 2'h2
`endif

// ---- design/pcs_stack_mem.v ----
`timescale 1ns/1ps
// ----------------------------------------
// Return stack storage, registered read
// ----------------------------------------
module pcs_stack_mem (
  // Clock
  input wire i_clk,
  // Write port
  input wire i_we,
  input wire [2:0] i_waddr,
  input wire [12:0] i_wdata,
  // Read port
  input wire [2:0] i_raddr,
  output reg [12:0] o_rdata
);
  reg [12:0] mem [0:7];

  // Storage is never cleared; entries are don't-care until pushed
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // pcs_stack_mem

// ---- design/pcs_stack_ptr.v ----
`timescale 1ns/1ps
`include "pcs_consts.vh"
// ----------------------------------------
// Circular stack pointer, wraps silently
// ----------------------------------------
module pcs_stack_ptr (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Operations
  input wire i_push,
  input wire i_pop,
  // Pointer
  output reg [2:0] o_ptr_q,
  output wire [2:0] o_top
);
  // Top of stack is the last written slot
  assign o_top = o_ptr_q - 3'h1;

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ptr_q <= 3'h0;
    end else if (i_push) begin
      o_ptr_q <= o_ptr_q + 3'h1;
    end else if (i_pop) begin
      o_ptr_q <= o_ptr_q - 3'h1;
    end
  end
endmodule // pcs_stack_ptr

// ---- test/pcs_core_chk.sv ----
`timescale 1ns/1ps
// ----
// Checker
// ----
module pcs_core_chk (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Core decode
  input wire i_step,
  input wire i_jump,
  input wire i_call,
  input wire [10:0] i_jump_addr,
  input wire i_return,
  input wire i_exit_with_literal_instr,
  input wire i_interrupt_exit_instr,
  input wire i_int_vector,
  input wire [12:0] i_vector_addr,
  input wire i_low_wr,
  input wire [7:0] i_low_wdata,
  input wire i_latch_wr,
  // Outputs
  input wire [12:0] o_pc,
  input wire [7:0] o_pc_high_latch,
  input wire s_axi_bvalid,
  input wire s_axi_bready
);
  wire pop = i_return | i_exit_with_literal_instr | i_interrupt_exit_instr;
  wire hi = i_int_vector | i_jump | i_call;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence pop_req;
    pop && !i_int_vector;
  endsequence
  reset_clears_pc_a: assert property ($rose(i_reset_n) |-> o_pc == 13'h0000)
    else $error("pc not cleared");
  step_inc_a: assert property (i_step && !pop && !hi && !i_low_wr && !$past(pop)
    |=> o_pc == $past(o_pc) + 13'h0001) else $error("bad increment");
  jump_page_a: assert property ((i_jump || i_call) && !i_int_vector && !$past(pop)
    |=> o_pc == {1'b0, $past(o_pc_high_latch[3]), $past(i_jump_addr)}) else $error("bad jump");
  low_load_a: assert property (i_low_wr && !hi && !$past(pop)
    |=> o_pc == {1'b0, $past(o_pc_high_latch[3:0]), $past(i_low_wdata)}) else $error("bad low");
  vector_load_a: assert property (i_int_vector |=> o_pc == $past(i_vector_addr))
    else $error("bad vector");
  latch_kept_a: assert property ((i_call || pop || i_int_vector) && !i_latch_wr
    |=> $stable(o_pc_high_latch)) else $error("latch changed");
  pop_hold_a: assert property (pop_req |=> $stable(o_pc))
    else $error("pc moved after pop");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
endmodule // pcs_core_chk

bind pcs_core pcs_core_chk u_chk (.*);

// ---- test/pcs_dec_model.sv ----
`timescale 1ns/1ps
// ----
// Core decode model, one op a cycle
// ----
module pcs_dec_model (
  // Clock
  input wire i_clk,
  // One-hot pulses and shared operand
  output logic [8:0] o_op,
  output logic [12:0] o_arg
);
  initial begin
    o_op = 9'h000;
    o_arg = 13'h0000;
  end
  task automatic issue(input int k, input logic [12:0] a);
    @(posedge i_clk);
    o_op <= 9'h001 << k;
    o_arg <= a;
    @(posedge i_clk);
    o_op <= 9'h000;
    // Stale operand toggled so it is never trusted
    o_arg <= ~a;
    // Nothing new in the cycle after a pop
    if (k >= 3 && k <= 5) @(posedge i_clk);
  endtask
endmodule // pcs_dec_model

// ---- test/pcs_core_tb.sv ----
`timescale 1ns/1ps
`include "pcs_consts.vh"
module pcs_core_tb;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [12:0] pc;
  logic [12:0] ret [1:10];
  logic [1:0] rs, rr;
  wire [7:0] lowb;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [12:0] o_pc, arg;
  wire [8:0] op;
  wire [7:0] latch;
  int n_mismatch = 0, n_tests = 0, i;
  always #2.5 i_clk = ~i_clk;
  pcs_dec_model u_dec (.i_clk(i_clk), .o_op(op), .o_arg(arg));
  pcs_core u_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_step(op[0]), .i_jump(op[1]), .i_call(op[2]),
    .i_jump_addr(arg[10:0]), .i_return(op[3]), .i_exit_with_literal_instr(op[4]),
    .i_interrupt_exit_instr(op[5]), .i_int_vector(op[6]), .i_vector_addr(arg),
    .i_low_wr(op[7]), .i_low_wdata(arg[7:0]), .i_latch_wr(op[8]), .i_latch_wdata(arg[7:0]),
    .o_pc(o_pc), .o_pc_low_byte(lowb), .o_pc_high_latch(latch),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task summarize;
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tmo(input int n);
    if (n >= 100) begin
      n_mismatch++;
      summarize;
    end
  endtask
  task axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(n);
  endtask
  task axr(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rr = rresp;
    rready <= 1'b0;
    tmo(n);
  endtask
  task cop(input int k, input logic [12:0] a, input logic [12:0] e);
    u_dec.issue(k, a);
    #1;
    chk("pc", o_pc, e);
    chk("low byte", lowb, e[7:0]);
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    chk("pc", o_pc, 13'h0000);
    axr(`PCS_ADDR_LATCH, rd);
    chk("latch", rd, 32'h0);
    $display("reset test done");
    for (i = 1; i <= 3; i++) begin
      cop(0, 13'h0000, i[12:0]);
    end
    axw(`PCS_ADDR_LATCH, 32'h0000_001D, rs);
    axw(`PCS_ADDR_LOW, 32'h0000_0034, rs);
    #1;
    chk("pc", o_pc, 13'h0D34);
    axr(`PCS_ADDR_LOW, rd);
    chk("low", rd, 32'h0000_0034);
    axr(`PCS_ADDR_LATCH, rd);
    chk("latch", rd, 32'h0000_001D);
    cop(7, 13'h00FF, 13'h0DFF);
    cop(0, 13'h0000, 13'h0E00);
    cop(7, 13'h0010, 13'h0D10);
    axw(4'hC, 32'h0000_00FF, rs);
    chk("bresp", rs, `PCS_RESP_SLVERR);
    axr(`PCS_ADDR_STAT, rd);
    chk("upper read", rd, 32'h0);
    chk("rresp", rr, `PCS_RESP_SLVERR);
    $display("register test done");
    cop(8, 13'h0008, 13'h0D10);
    cop(1, 13'h0123, 13'h0923);
    pc = 13'h0923;
    for (i = 1; i <= 10; i++) begin
      ret[i] = pc + 13'h0001;
      pc = {2'b01, i[6:0], 4'h0};
      cop(2, {2'b00, i[6:0], 4'h0}, pc);
    end
    for (i = 0; i < 9; i++) begin
      pc = ret[10 - i % 8];
      cop(3 + i % 3, 13'h0000, pc);
    end
    axr(`PCS_ADDR_LATCH, rd);
    chk("latch", rd, 32'h0000_0008);
    $display("stack test done");
    cop(6, 13'h1FFF, 13'h1FFF);
    cop(6, 13'h0004, 13'h0004);
    cop(5, 13'h0000, 13'h1FFF);
    cop(0, 13'h0000, 13'h0000);
    cop(3, 13'h0000, pc);
    $display("vector test done");
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    chk("pc", o_pc, 13'h0000);
    axr(`PCS_ADDR_LATCH, rd);
    chk("latch", rd, 32'h0);
    chk("rresp", rr, `PCS_RESP_OKAY);
    cop(0, 13'h0000, 13'h0001);
    $display("second reset test done");
    summarize;
  end
endmodule // pcs_core_tb
